/* File: design/bab_alarm_broadcaster.sv */
`timescale 1ns/1ps
// How it works
// (RQ1) critical condition makes the pack send alarm notices to host and charger
// (RQ2) notice payload is the condition word with low nibble forced to ones
// (RQ3) notices repeat every ten seconds while any alarm remains
// (RQ4) no notice goes out before ten seconds after power-on
// (RQ5) suppress mode bit set to one stops automatic notices
// (RQ6) when suppressed, host polls the condition word every ten seconds
// (RQ7) polling host inhibits charging on charge alarms until all clear
// (RQ8) status bits seven to four never trigger a notice
// (RQ9) notice command byte equals the pack's own bus address
// (RQ10) capacity and time alarms go to host only; others also charger
// (RQ11) alarms sit at 0x8000, 0x4000, 0x1000, 0x0800, 0x0200 and 0x0100
// (RQ12) bit 9 set while charge below nonzero capacity threshold
// (RQ13) bit 8 set while runtime below nonzero runtime threshold
// (RQ14) bit 12 follows internal over-temperature
// (RQ15) bit 15 set when full yet still charged; cleared when charging stops
// (RQ16) bit 11 set when depleted; cleared when discharge stops
// (RQ17) bit 14 set whenever charging should be suspended
// (RQ18) bit 7 set on calibration; cleared when calibration is lost
// (RQ19) bit 6 set while discharging, cleared while charging
// (RQ20) bit 5 set while pack is full
// (RQ21) bit 4 set when depleted; cleared only above twenty percent charge
// (RQ22) charger stops charging on an over-temperature notice
// (RQ23) charge-stop flag clears when charging is no longer detected
// (RQ24) notices go out as master word-write transfers
// (RQ25) reserved bits 13 and 10 read zero and never trigger
module bab_alarm_broadcaster #(
    parameter int unsigned PERIOD_CYCLES  = bab_pkg::ALARM_PERIOD_CYC,
    parameter int unsigned HOLDOFF_CYCLES = bab_pkg::ON_HOLDOFF_CYC,
    parameter logic [7:0]  OWN_ADDR       = bab_pkg::OWN_ADDR_DEF,
    parameter logic [7:0]  HOST_ADDR      = bab_pkg::HOST_ADDR_DEF,
    parameter logic [7:0]  CHARGER_ADDR   = bab_pkg::CHARGER_ADDR_DEF
) (
    // pack controller clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,

    // pack measurements and events, same clock
    input  wire logic              charging,
    input  wire logic              pack_full,
    input  wire logic              over_temp,
    input  wire logic              charge_suspend,
    input  wire logic              pack_depleted,
    input  wire logic              discharge_active,
    input  wire logic              calib_done,
    input  wire logic              calib_lost,
    input  wire logic [15:0]       charge_left,
    input  wire logic [15:0]       capacity_threshold,
    input  wire logic [15:0]       mean_runtime_left,
    input  wire logic [15:0]       runtime_threshold,
    input  wire logic [7:0]        charge_percent,
    input  wire logic [3:0]        error_code,

    // mode
    input  wire logic              alarm_suppress,

    // status toward the pack controller
    output logic [15:0]            pack_condition_word,
    output logic                   notice_busy,

    // bus engine side, link clock
    input  wire logic              link_clk,
    input  wire logic              xfer_done,
    output logic                   xfer_valid,
    output bab_pkg::bab_xfer_t     xfer
);

    // ---------------- condition word ----------------
    logic [15:0] cond_q;
    logic [15:0] cond_d;

    logic over_chg_d;
    logic chg_stop_d;
    logic dis_stop_d;
    logic cal_valid_d;
    logic empty_d;
    logic cap_low_w;
    logic time_low_w;
    logic pct_above_w;

    // zero threshold disables the comparison
    assign cap_low_w = (capacity_threshold != 16'h0000) &&
                       (charge_left < capacity_threshold);          // RQ12
    assign time_low_w = (runtime_threshold != 16'h0000) &&
                        (mean_runtime_left < runtime_threshold);    // RQ13
    assign pct_above_w = charge_percent > bab_pkg::EMPTY_RELEASE_PCT;

    // sticky flags: setting wins over clearing in the same cycle
    assign over_chg_d = (pack_full && charging) ||
                        (cond_q[bab_pkg::BIT_OVER_CHG] && charging); // RQ15
    assign chg_stop_d = charge_suspend ||
                        (cond_q[bab_pkg::BIT_CHG_STOP] && charging); // RQ17 RQ23
    assign dis_stop_d = pack_depleted ||
                        (cond_q[bab_pkg::BIT_DIS_STOP] &&
                         discharge_active);                          // RQ16
    assign cal_valid_d = calib_done ||
                         (cond_q[bab_pkg::BIT_CAL_VALID] &&
                          !calib_lost);                              // RQ18
    assign empty_d = pack_depleted ||
                     (cond_q[bab_pkg::BIT_EMPTY] && !pct_above_w);   // RQ21

    always_comb begin
        cond_d = 16'h0000;                                           // RQ25
        cond_d[bab_pkg::BIT_OVER_CHG]  = over_chg_d;                 // RQ11
        cond_d[bab_pkg::BIT_CHG_STOP]  = chg_stop_d;
        cond_d[bab_pkg::BIT_OVER_TEMP] = over_temp;                  // RQ14
        cond_d[bab_pkg::BIT_DIS_STOP]  = dis_stop_d;
        cond_d[bab_pkg::BIT_CAP_LOW]   = cap_low_w;
        cond_d[bab_pkg::BIT_TIME_LOW]  = time_low_w;
        cond_d[bab_pkg::BIT_CAL_VALID] = cal_valid_d;
        cond_d[bab_pkg::BIT_DISCHG]    = !charging;                  // RQ19
        cond_d[bab_pkg::BIT_FULL]      = pack_full;                  // RQ20
        cond_d[bab_pkg::BIT_EMPTY]     = empty_d;
        cond_d[3:0]                    = error_code;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cond_q <= 16'h0000;
        end else begin
            cond_q <= cond_d;
        end
    end

    assign pack_condition_word = cond_q;

    // ---------------- alarm detection ----------------
    logic [15:0] alarm_bits_w;
    logic        alarm_any_w;
    logic        alarm_any_q;
    logic        alarm_rise_w;

    // status bits and reserved bits are masked out
    assign alarm_bits_w = cond_q & bab_pkg::ALARM_MASK;             // RQ8 RQ25
    assign alarm_any_w  = alarm_bits_w != 16'h0000;
    assign alarm_rise_w = alarm_any_w && !alarm_any_q;              // RQ1

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_any_q <= 1'b0;
        end else begin
            alarm_any_q <= alarm_any_w;
        end
    end

    // ---------------- power-on holdoff ----------------
    logic [31:0] hold_cnt_q;
    logic        on_ready_q;
    logic        hold_end_w;

    assign hold_end_w = hold_cnt_q == 32'(HOLDOFF_CYCLES - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt_q <= 32'h0000_0000;
            on_ready_q <= 1'b0;
        end else if (!on_ready_q) begin
            hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            on_ready_q <= hold_end_w;                               // RQ4
        end
    end

    // ---------------- repeat timer ----------------
    logic [31:0] per_cnt_q;
    logic        per_end_w;
    logic        send_start_w;

    // fires two short: one cycle to pend, one to start the round
    assign per_end_w = per_cnt_q == 32'(PERIOD_CYCLES - 2);

    // restarts at each round so rounds stay ten seconds apart
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt_q <= 32'h0000_0000;
        end else if (send_start_w || !alarm_any_w || per_end_w) begin
            per_cnt_q <= 32'h0000_0000;
        end else begin
            per_cnt_q <= per_cnt_q + 32'h0000_0001;                 // RQ3
        end
    end

    // ---------------- pending round ----------------
    logic pending_q;
    logic pending_d;

    // a rise or expiry in the same cycle as a start still counts
    assign pending_d = alarm_any_w && !alarm_suppress &&            // RQ5
                       (alarm_rise_w || (per_end_w && alarm_any_q) ||
                        (pending_q && !send_start_w));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end

    // ---------------- sender ----------------
    bab_pkg::bab_state_t state_q;
    bab_pkg::bab_state_t state_d;

    logic [15:0] payload_q;
    logic [15:0] payload_d;
    logic        req_tgl_q;
    logic        req_tgl_d;
    logic [7:0]  dest_q;
    logic [7:0]  dest_d;
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        ack_seen_q;
    logic        ack_new_w;
    logic        to_charger_w;
    logic        is_idle_w;

    assign is_idle_w    = state_q == bab_pkg::ST_IDLE;
    assign send_start_w = is_idle_w && pending_q && on_ready_q &&
                          !alarm_suppress;                          // RQ4 RQ5
    assign ack_new_w    = ack_s2_q != ack_seen_q;
    assign to_charger_w = (payload_q & bab_pkg::CHARGER_MASK) !=
                          16'h0000;                                 // RQ10

    always_comb begin
        state_d   = state_q;
        payload_d = payload_q;
        req_tgl_d = req_tgl_q;
        dest_d    = dest_q;
        case (state_q)
            bab_pkg::ST_IDLE: begin
                if (send_start_w) begin
                    payload_d = cond_q | bab_pkg::NIBBLE_FORCE;     // RQ2
                    state_d   = bab_pkg::ST_HOST_REQ;
                end
            end
            bab_pkg::ST_HOST_REQ: begin
                dest_d    = HOST_ADDR;                              // RQ10
                req_tgl_d = !req_tgl_q;
                state_d   = bab_pkg::ST_HOST_WAIT;
            end
            bab_pkg::ST_HOST_WAIT: begin
                if (ack_new_w) begin
                    state_d = to_charger_w ? bab_pkg::ST_CHG_REQ
                                           : bab_pkg::ST_IDLE;
                end
            end
            bab_pkg::ST_CHG_REQ: begin
                dest_d    = CHARGER_ADDR;
                req_tgl_d = !req_tgl_q;
                state_d   = bab_pkg::ST_CHG_WAIT;
            end
            bab_pkg::ST_CHG_WAIT: begin
                if (ack_new_w) begin
                    state_d = bab_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = bab_pkg::ST_IDLE;
            end
        endcase
    end

    // payload changes before the toggle and dest on the same edge, so the link side
    // samples them stable after its two-stage synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= bab_pkg::ST_IDLE;
            payload_q <= 16'h0000;
            req_tgl_q <= 1'b0;
            dest_q    <= 8'h00;
        end else begin
            state_q   <= state_d;
            payload_q <= payload_d;
            req_tgl_q <= req_tgl_d;
            dest_q    <= dest_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_seen_q <= 1'b0;
        end else if (ack_new_w) begin
            ack_seen_q <= ack_s2_q;
        end
    end

    logic busy_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= state_d != bab_pkg::ST_IDLE;
        end
    end

    assign notice_busy = busy_q;

    // ack toggle from the link domain
    logic lk_ack_tgl_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= lk_ack_tgl_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ---------------- link domain ----------------
    logic               lk_req_s1_q;
    logic               lk_req_s2_q;
    logic               lk_req_seen_q;
    logic               lk_valid_q;
    bab_pkg::bab_xfer_t lk_xfer_q;
    bab_pkg::bab_xfer_t lk_xfer_d;
    logic               lk_new_w;
    logic               lk_fin_w;

    assign lk_new_w = (lk_req_s2_q != lk_req_seen_q) && !lk_valid_q;
    assign lk_fin_w = lk_valid_q && xfer_done;

    // command byte carries the pack's own address
    assign lk_xfer_d = '{addr: dest_q,
                         cmd:  OWN_ADDR,                            // RQ9
                         word: payload_q};

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_req_s1_q <= 1'b0;
            lk_req_s2_q <= 1'b0;
        end else begin
            lk_req_s1_q <= req_tgl_q;
            lk_req_s2_q <= lk_req_s1_q;
        end
    end

    // word write held until the bus engine reports it done
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_req_seen_q <= 1'b0;
            lk_valid_q    <= 1'b0;
            lk_xfer_q     <= '0;
            lk_ack_tgl_q  <= 1'b0;
        end else if (lk_new_w) begin
            lk_req_seen_q <= lk_req_s2_q;
            lk_valid_q    <= 1'b1;                                  // RQ24
            lk_xfer_q     <= lk_xfer_d;
        end else if (lk_fin_w) begin
            lk_valid_q    <= 1'b0;
            lk_ack_tgl_q  <= !lk_ack_tgl_q;
        end
    end

    assign xfer_valid = lk_valid_q;
    assign xfer       = lk_xfer_q;

endmodule : bab_alarm_broadcaster

/* File: design/bab_pkg.sv */
package bab_pkg;

    // pack condition word bit positions
    localparam int unsigned BIT_OVER_CHG   = 15;
    localparam int unsigned BIT_CHG_STOP   = 14;
    localparam int unsigned BIT_OVER_TEMP  = 12;
    localparam int unsigned BIT_DIS_STOP   = 11;
    localparam int unsigned BIT_CAP_LOW    = 9;
    localparam int unsigned BIT_TIME_LOW   = 8;
    localparam int unsigned BIT_CAL_VALID  = 7;
    localparam int unsigned BIT_DISCHG     = 6;
    localparam int unsigned BIT_FULL       = 5;
    localparam int unsigned BIT_EMPTY      = 4;

    // masks over the condition word
    localparam logic [15:0] ALARM_MASK     = 16'hdb00;
    localparam logic [15:0] CHARGER_MASK   = 16'hd800;
    localparam logic [15:0] NIBBLE_FORCE   = 16'h000f;

    // notice command code; equals the pack's own bus address
    localparam logic [7:0]  ALARM_NOTICE_WORD = 8'h16;
    localparam logic [7:0]  OWN_ADDR_DEF      = ALARM_NOTICE_WORD;
    localparam logic [7:0]  HOST_ADDR_DEF     = 8'h20;
    localparam logic [7:0]  CHARGER_ADDR_DEF  = 8'h22;

    // empty flag releases above this charge percentage
    localparam logic [7:0]  EMPTY_RELEASE_PCT = 8'h14;

    // timing
    localparam longint unsigned CLK_HZ          = 125_000_000;
    localparam longint unsigned ALARM_PERIOD_S  = 10;
    localparam longint unsigned ON_HOLDOFF_S    = 10;
    localparam int unsigned ALARM_PERIOD_CYC =
        int'(ALARM_PERIOD_S * CLK_HZ);
    localparam int unsigned ON_HOLDOFF_CYC =
        int'(ON_HOLDOFF_S * CLK_HZ);

    // one word-write transfer handed to the bus engine
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  cmd;
        logic [15:0] word;
    } bab_xfer_t;

    typedef enum logic [4:0] {
        ST_IDLE      = 5'b00001,
        ST_HOST_REQ  = 5'b00010,
        ST_HOST_WAIT = 5'b00100,
        ST_CHG_REQ   = 5'b01000,
        ST_CHG_WAIT  = 5'b10000
    } bab_state_t;

endpackage : bab_pkg

/* File: tb/bab_alarm_checker.sv */
`timescale 1ns/1ps
module bab_alarm_checker #(
    parameter int unsigned HOLDOFF_CYCLES = 100,
    parameter logic [7:0]  OWN_ADDR       = 8'h16,
    parameter logic [7:0]  HOST_ADDR      = 8'h20,
    parameter logic [7:0]  CHARGER_ADDR   = 8'h22
) (
    // pack side
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic               charging,
    input wire logic               pack_full,
    input wire logic               over_temp,
    input wire logic               charge_suspend,
    input wire logic               pack_depleted,
    input wire logic [15:0]        charge_left,
    input wire logic [15:0]        capacity_threshold,
    input wire logic [7:0]         charge_percent,
    input wire logic               alarm_suppress,
    input wire logic [15:0]        pack_condition_word,
    input wire logic               notice_busy,
    // link side
    input wire logic               link_clk,
    input wire logic               xfer_done,
    input wire logic               xfer_valid,
    input wire bab_pkg::bab_xfer_t xfer
);
    logic [31:0] up_q;
    wire  [15:0] w = pack_condition_word;

    // saturating count of cycles since reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            up_q <= '0;
        else if (up_q < HOLDOFF_CYCLES)
            up_q <= up_q + 32'h1;
    end

    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        w[13] == 1'b0 && w[10] == 1'b0) else $error("reserved bit set");
    a_temp_follow: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> w[12] == $past(over_temp)) else $error("temp bit");
    a_full_dis: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> w[5] == $past(pack_full) && w[6] == !$past(charging))
        else $error("full or discharging bit");
    a_cap_compare: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> w[9] == ($past(capacity_threshold) != 16'h0000 &&
        $past(charge_left) < $past(capacity_threshold))) else $error("cap bit");
    a_overchg_set: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n && charging && pack_full) |-> w[15])
        else $error("overcharge not set");
    a_charge_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n && !charging && !charge_suspend) |-> !w[15] && !w[14])
        else $error("charge alarms not cleared");
    a_suspend_set: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n && charge_suspend) |-> w[14]) else $error("suspend bit");
    a_empty_release: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(charge_percent) > 8'h14 && !$past(pack_depleted)
        |-> !w[4]) else $error("empty bit not released");
    a_holdoff_wait: assert property (@(posedge clk) disable iff (!reset_n)
        notice_busy |-> up_q >= HOLDOFF_CYCLES) else $error("notice too early");
    a_suppress_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        alarm_suppress [*6] |-> !$rose(notice_busy)) else $error("round while off");
    a_xfer_hold: assert property (@(posedge link_clk) disable iff (!reset_n)
        xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer))
        else $error("transfer dropped or changed");
    a_cmd_nibble: assert property (@(posedge link_clk) disable iff (!reset_n)
        xfer_valid |-> xfer.cmd == OWN_ADDR && xfer.word[3:0] == 4'hf)
        else $error("bad command or nibble");
    a_route_ok: assert property (@(posedge link_clk) disable iff (!reset_n)
        xfer_valid |-> xfer.addr == HOST_ADDR || (xfer.addr == CHARGER_ADDR &&
        (xfer.word & bab_pkg::CHARGER_MASK) != 16'h0000)) else $error("bad route");
    a_alarm_cause: assert property (@(posedge link_clk) disable iff (!reset_n)
        xfer_valid |-> (xfer.word & bab_pkg::ALARM_MASK) != 16'h0000)
        else $error("notice without alarm");

    c_charger: cover property (@(posedge link_clk) xfer_valid &&
        xfer.addr == CHARGER_ADDR);
    c_round: cover property (@(posedge clk) $rose(notice_busy));
    c_empty: cover property (@(posedge clk) w[4] && w[11]);
endmodule : bab_alarm_checker

bind bab_alarm_broadcaster bab_alarm_checker #(
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES), .OWN_ADDR(OWN_ADDR),
    .HOST_ADDR(HOST_ADDR), .CHARGER_ADDR(CHARGER_ADDR)
) u_chk (.clk, .reset_n, .charging, .pack_full, .over_temp, .charge_suspend,
    .pack_depleted, .charge_left, .capacity_threshold, .charge_percent,
    .alarm_suppress, .pack_condition_word, .notice_busy, .link_clk,
    .xfer_done, .xfer_valid, .xfer);

/* File: tb/bab_engine_model.sv */
`timescale 1ns/1ps
module bab_engine_model (
    // link clock and reset
    input wire logic               link_clk,
    input wire logic               reset_n,
    // extra link cycles before completing a transfer
    input wire logic [7:0]         stall,
    // transfer handshake
    input wire logic               xfer_valid,
    input wire bab_pkg::bab_xfer_t xfer,
    output logic                   xfer_done
);
    bab_pkg::bab_xfer_t q[$];
    int                 cnt;

    // one-cycle done pulse; a fresh request is never ended in its first cycle
    always @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            xfer_done <= 1'b0;
            cnt = 0;
        end else if (xfer_done) begin
            xfer_done <= 1'b0;
        end else if (xfer_valid) begin
            if (cnt >= int'(stall)) begin
                q.push_back(xfer);
                xfer_done <= 1'b1;
                cnt = 0;
            end else begin
                cnt = cnt + 1;
            end
        end
    end
endmodule : bab_engine_model

/* File: tb/bab_alarm_broadcaster_tb.sv */
`timescale 1ns/1ps
module bab_alarm_broadcaster_tb;
    localparam int unsigned PER  = 2000;
    localparam int unsigned HOLD = 1000;
    localparam logic [7:0]  HOST = bab_pkg::HOST_ADDR_DEF;
    localparam logic [7:0]  CHGR = bab_pkg::CHARGER_ADDR_DEF;

    logic        clk, reset_n, link_clk, xfer_done, xfer_valid, notice_busy;
    logic        charging, pack_full, over_temp, charge_suspend, pack_depleted;
    logic        discharge_active, calib_done, calib_lost, alarm_suppress;
    logic [15:0] charge_left, capacity_threshold, mean_runtime_left;
    logic [15:0] runtime_threshold, pack_condition_word;
    logic [7:0]  charge_percent, stall;
    logic [3:0]  error_code;
    bab_pkg::bab_xfer_t xfer;
    int          errors = 0, n_checks = 0, cyc = 0, base, t1;

    bab_alarm_broadcaster #(.PERIOD_CYCLES(PER), .HOLDOFF_CYCLES(HOLD)) u_dut (
        .clk, .reset_n, .charging, .pack_full, .over_temp, .charge_suspend,
        .pack_depleted, .discharge_active, .calib_done, .calib_lost,
        .charge_left, .capacity_threshold, .mean_runtime_left,
        .runtime_threshold, .charge_percent, .error_code, .alarm_suppress,
        .pack_condition_word, .notice_busy, .link_clk, .xfer_done,
        .xfer_valid, .xfer);
    bab_engine_model u_eng (.link_clk, .reset_n, .stall, .xfer_valid, .xfer,
        .xfer_done);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // unrelated phase to clk
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // inputs land one edge later, the word one edge after that
    task automatic word(input logic [15:0] mask, input logic [15:0] exp);
        tick(3);
        chk({16'h0000, pack_condition_word & mask}, {16'h0000, exp});
    endtask : word

    task automatic wait_q(input int n);
        int k;
        k = 0;
        while (u_eng.q.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk(32'(u_eng.q.size() >= n), 32'h1);
    endtask : wait_q

    initial begin
        reset_n = 1'b1;
        {charging, pack_full, over_temp, charge_suspend} = '0;
        {pack_depleted, discharge_active, calib_done, calib_lost} = '0;
        {charge_left, capacity_threshold, mean_runtime_left} = '0;
        {runtime_threshold, charge_percent, error_code} = '0;
        alarm_suppress = 1'b0;
        stall = 8'h00;
        // a real falling edge resets the link side before its first edge
        #1 reset_n = 1'b0;
        tick(10);
        reset_n <= 1'b1;
        charging <= 1'b1;
        pack_full <= 1'b1;
        error_code <= 4'h5;
        word(16'h906f, 16'h8025);
        tick(HOLD - 100);
        chk(u_eng.q.size(), 32'h0);
        chk(32'(notice_busy), 32'h0);
        wait_q(2);
        chk(u_eng.q[0], {HOST, 8'h16, 16'h802f});
        chk(u_eng.q[1], {CHGR, 8'h16, 16'h802f});
        charging <= 1'b0;
        pack_full <= 1'b0;
        word(16'h8060, 16'h0040);
        // slow far end; capacity and runtime alarms go to the host only
        stall <= 8'h03;
        capacity_threshold <= 16'd100;
        charge_left <= 16'd50;
        runtime_threshold <= 16'd10;
        mean_runtime_left <= 16'd5;
        word(16'h0300, 16'h0300);
        base = u_eng.q.size();
        wait_q(base + 1);
        t1 = cyc;
        wait_q(base + 2);
        chk(32'(cyc - t1 > PER - 60 && cyc - t1 < PER + 60), 32'h1);
        chk(u_eng.q[base], {HOST, 8'h16, 16'h034f});
        chk(u_eng.q[base + 1], {HOST, 8'h16, 16'h034f});
        capacity_threshold <= 16'h0000;
        mean_runtime_left <= 16'd20;
        word(16'h0300, 16'h0000);
        // status bits alone stay silent
        base = u_eng.q.size();
        pack_full <= 1'b1;
        calib_done <= 1'b1;
        word(16'h00e0, 16'h00e0);
        tick(300);
        tick(PER + 500);
        chk(u_eng.q.size(), base);
        calib_done <= 1'b0;
        calib_lost <= 1'b1;
        word(16'h0080, 16'h0000);
        calib_lost <= 1'b0;
        alarm_suppress <= 1'b1;
        tick(3);
        base = u_eng.q.size();
        over_temp <= 1'b1;
        charging <= 1'b1;
        charge_suspend <= 1'b1;
        word(16'h5000, 16'h5000);
        charge_suspend <= 1'b0;
        word(16'h4000, 16'h4000);
        charging <= 1'b0;
        over_temp <= 1'b0;
        word(16'h5000, 16'h0000);
        discharge_active <= 1'b1;
        pack_depleted <= 1'b1;
        charge_percent <= 8'd10;
        word(16'h0810, 16'h0810);
        pack_depleted <= 1'b0;
        discharge_active <= 1'b0;
        charge_percent <= 8'd20;
        word(16'h0810, 16'h0010);
        charge_percent <= 8'd21;
        word(16'h0010, 16'h0000);
        tick(PER);
        chk(u_eng.q.size(), base);
        end_of_test();
    end

    // about six times the expected run
    initial begin
        #400000;
        errors++;
        end_of_test();
    end
endmodule : bab_alarm_broadcaster_tb
